// ==== adc_cfg_pkg.sv ====
// Purpose: shared constants and types for the converter configuration bank
// Assumes: 16-bit registers at 6-bit word addresses
// Notes: crc step helper is called only by the bank's map watcher
package adc_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int CHAN_N = 8;

  localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h01;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 6'h02;
  localparam logic [ADDR_W-1:0] CLOCK_ADDR = 6'h03;

  localparam logic [DATA_W-1:0] MODE_RESET = 16'h0510;
  localparam logic [DATA_W-1:0] CLOCK_RESET = 16'hff0e;
  // reserved bits are never stored, so they always read zero
  localparam logic [DATA_W-1:0] MODE_WMASK = 16'h3f1f;
  localparam logic [DATA_W-1:0] CLOCK_WMASK = 16'hffdf;
  localparam int MODE_RESET_BIT = 10;

  localparam logic [15:0] CRC_POLY_CCITT = 16'h1021;
  localparam logic [15:0] CRC_POLY_ANSI = 16'h8005;
  localparam logic [15:0] CRC_SEED = 16'hffff;

  localparam int CLK_PERIOD_NS = 4;
  localparam int READY_PULSE_NS = 8;
  localparam int READY_PULSE_RAW =
    (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READY_PULSE_CYCLES =
    (READY_PULSE_RAW < 1) ? 1 : READY_PULSE_RAW;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic reg_crc_en;
    logic rx_crc_en;
    logic crc_type;
    logic reset_seen;
    logic [1:0] word_length_select;
    logic [2:0] rsvd_lo;
    logic timeout_enable;
    logic [1:0] ready_pin_source_select;
    logic ready_pin_idle_float;
    logic ready_pin_pulse_format;
  } mode_cfg_t;

  typedef struct packed {
    logic [7:0] chan_convert_enable;
    logic xtal_disable;
    logic extref_enable;
    logic rsvd;
    logic [2:0] oversampling_ratio_select;
    logic [1:0] power_mode;
  } clock_cfg_t;

  localparam logic [1:0] SRC_LAGGING = 2'h0;
  localparam logic [1:0] SRC_ANY = 2'h1;

  typedef enum logic [3:0] {
    PIN_IDLE = 4'h1,
    PIN_LEVEL = 4'h2,
    PIN_PULSE = 4'h4,
    PIN_SPENT = 4'h8
  } pin_state_t;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16_word(input logic [31:0] data,
                                             input logic ansi);
    logic [15:0] crc;
    logic [15:0] poly;
    logic fb;
    crc = CRC_SEED;
    poly = ansi ? CRC_POLY_ANSI : CRC_POLY_CCITT;
    for (int i = 31; i >= 0; i--) begin
      fb = crc[15] ^ data[i];
      crc = {crc[14:0], 1'b0};
      if (fb) begin
        crc = crc ^ poly;
      end
    end
    return crc;
  endfunction

endpackage

// ==== regmap_crc_watch.sv ====
// Purpose: watches the configuration map for unexpected content changes
// Assumes: map_written pulses in the cycle a host write is taken
// Notes: reference is retaken one cycle after each write
`timescale 1ns/1ps
`default_nettype none
module regmap_crc_watch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // map under watch
  input wire logic enable,
  input wire logic crc_type,
  input wire logic [31:0] map_word,
  input wire logic map_written,
  // result
  output logic fault_event
);
  import adc_cfg_pkg::*;

  logic [15:0] ref_crc;
  logic [15:0] next_ref_crc;
  logic written_q;
  logic next_written_q;
  logic fault_q;
  logic next_fault_q;
  logic [15:0] crc_now;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    crc_now = crc16_word(map_word, crc_type);
    next_written_q = map_written;
    next_ref_crc = ref_crc;
    next_fault_q = 1'b0;
    // a legal write changes the map too, so rearm rather than flag it
    if (!enable || written_q || map_written) begin
      next_ref_crc = crc_now;
    end else if (crc_now != ref_crc) begin
      next_fault_q = 1'b1;
      next_ref_crc = crc_now;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_crc <= 16'h0000;
      written_q <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      ref_crc <= next_ref_crc;
      written_q <= next_written_q;
      fault_q <= next_fault_q;
    end
  end

  assign fault_event = fault_q;

endmodule
`default_nettype wire

// ==== adc_config_regs.sv ====
// Purpose: interface-mode, channel/clock and status registers of the
//   eight-channel converter, plus the data-ready pin driver
// Assumes: the serial frame layer decodes frames into word accesses
// Notes: status read clears the two crc fault flags
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - mode bit 13 enables map crc, reset zero
// - mode bit 12 enables input crc, reset zero
// - mode bit 11 picks ccitt or ansi
// - reset bit reads one; writing zero clears
// - bits 9:8 select word length, default 24
// - bits 3:2 pick data-ready pin source
// - bit 1 floats idle pin, else high
// - bit 0 picks low level or pulse
// - clock bits 15:8 enable channels, reset one
// - clock register at 03h resets ff0eh
// - flag when map crc changes while enabled
// - flag failed input frame crc when enabled
// - per-channel new data status bits
// - three-bit oversampling select, default 1024
module adc_config_regs #(
  parameter int PULSE_CYCLES = adc_cfg_pkg::READY_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoded register access
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] reg_wdata,
  output logic [adc_cfg_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // frame checker and converters
  input wire logic frame_crc_fail,
  input wire logic [adc_cfg_pkg::CHAN_N-1:0] conv_done,
  input wire logic data_frame_read,
  // configuration to the rest of the device
  output adc_cfg_pkg::mode_cfg_t cfg_mode,
  output adc_cfg_pkg::clock_cfg_t cfg_clock,
  // data-ready pin
  output logic data_ready_pin_out,
  output logic data_ready_pin_oe
);
  import adc_cfg_pkg::*;

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);

  mode_cfg_t mode;
  mode_cfg_t next_mode;
  clock_cfg_t clock;
  clock_cfg_t next_clock;
  logic map_fault;
  logic next_map_fault;
  logic frame_fault;
  logic next_frame_fault;
  logic [CHAN_N-1:0] new_data;
  logic [CHAN_N-1:0] next_new_data;
  logic [DATA_W-1:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic [DATA_W-1:0] status_word;
  logic map_fault_event;
  logic wr_mode;
  logic wr_clock;
  logic rd_status;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and sticky flags

  always_comb begin
    wr_mode = reg_write && (reg_addr == MODE_ADDR);
    wr_clock = reg_write && (reg_addr == CLOCK_ADDR);
    rd_status = reg_read && (reg_addr == STATUS_ADDR);
    next_mode = mode;
    next_clock = clock;
    if (wr_mode) begin
      next_mode = mode_cfg_t'(reg_wdata & MODE_WMASK);
      // reset flag can only be cleared by the host, never set
      next_mode.reset_seen =
        mode.reset_seen & reg_wdata[MODE_RESET_BIT];
    end
    if (wr_clock) begin
      next_clock = clock_cfg_t'(reg_wdata & CLOCK_WMASK);
    end
    // set beats clear on every hardware flag
    next_map_fault = (map_fault && !rd_status) || map_fault_event;
    next_frame_fault = (frame_fault && !rd_status)
      || (frame_crc_fail && mode.rx_crc_en);
    next_new_data = (data_frame_read ? '0 : new_data)
      | (conv_done & clock.chan_convert_enable);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= mode_cfg_t'(MODE_RESET);
      clock <= clock_cfg_t'(CLOCK_RESET);
      map_fault <= 1'b0;
      frame_fault <= 1'b0;
      new_data <= '0;
    end else begin
      mode <= next_mode;
      clock <= next_clock;
      map_fault <= next_map_fault;
      frame_fault <= next_frame_fault;
      new_data <= next_new_data;
    end
  end

  assign cfg_mode = mode;
  assign cfg_clock = clock;

  ////////////////////////////////////////////////////////////////////////////
  // register map crc watch

  regmap_crc_watch u_watch (
    .clk(clk),
    .rst(rst),
    .enable(mode.reg_crc_en),
    .crc_type(mode.crc_type),
    .map_word({mode, clock}),
    .map_written(wr_mode || wr_clock),
    .fault_event(map_fault_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    status_word = {2'h0, map_fault, frame_fault, mode.crc_type,
                   mode.reset_seen, mode.word_length_select,
                   new_data};
    next_reg_rdata = reg_rdata;
    next_reg_rvalid = reg_read;
    if (reg_read) begin
      case (reg_addr)
        STATUS_ADDR: next_reg_rdata = status_word;
        MODE_ADDR: next_reg_rdata = DATA_W'(mode);
        CLOCK_ADDR: next_reg_rdata = DATA_W'(clock);
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data-ready pin

  pin_state_t pin_state;
  pin_state_t next_pin_state;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] next_pulse_cnt;
  logic ready_active;
  logic [CHAN_N-1:0] ready_enabled;
  logic pin_low;
  logic next_pin_out;
  logic next_pin_oe;

  always_comb begin
    ready_enabled = new_data & clock.chan_convert_enable;
    // leading channel is the first enabled flag to rise, which the
    // shared clear makes the same term as the any-channel case
    case (mode.ready_pin_source_select)
      SRC_LAGGING: ready_active = (|clock.chan_convert_enable)
        && (ready_enabled == clock.chan_convert_enable);
      SRC_ANY: ready_active = |ready_enabled;
      default: ready_active = |ready_enabled;
    endcase
    next_pin_state = pin_state;
    next_pulse_cnt = pulse_cnt;
    case (pin_state)
      PIN_IDLE: begin
        next_pulse_cnt = '0;
        if (ready_active) begin
          next_pin_state = mode.ready_pin_pulse_format ?
            PIN_PULSE : PIN_LEVEL;
        end
      end
      PIN_LEVEL: begin
        if (!ready_active) begin
          next_pin_state = PIN_IDLE;
        end
      end
      PIN_PULSE: begin
        next_pulse_cnt = pulse_cnt + CNT_W'(1);
        if (pulse_cnt == PULSE_LAST) begin
          next_pin_state = PIN_SPENT;
        end
      end
      PIN_SPENT: begin
        if (!ready_active) begin
          next_pin_state = PIN_IDLE;
        end
      end
      default: next_pin_state = PIN_IDLE;
    endcase
    pin_low = (next_pin_state == PIN_LEVEL) || (next_pin_state == PIN_PULSE);
    next_pin_out = !pin_low;
    next_pin_oe = pin_low || !mode.ready_pin_idle_float;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_state <= PIN_IDLE;
      pulse_cnt <= '0;
      data_ready_pin_out <= 1'b1;
      data_ready_pin_oe <= 1'b1;
    end else begin
      pin_state <= next_pin_state;
      pulse_cnt <= next_pulse_cnt;
      data_ready_pin_out <= next_pin_out;
      data_ready_pin_oe <= next_pin_oe;
    end
  end

endmodule
`default_nettype wire

// ==== adc_config_regs_checker.sv ====
// Purpose: port assertions for the configuration bank
// Assumes: one clock, async active-high reset
// Notes: pulse width is measured by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_checker #(
  parameter int PULSE_CYCLES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [adc_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // events and outputs
  input wire logic frame_crc_fail,
  input wire logic [adc_cfg_pkg::CHAN_N-1:0] conv_done,
  input wire logic data_frame_read,
  input wire adc_cfg_pkg::mode_cfg_t cfg_mode,
  input wire adc_cfg_pkg::clock_cfg_t cfg_clock,
  input wire logic data_ready_pin_out,
  input wire logic data_ready_pin_oe
);
  import adc_cfg_pkg::*;
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_mode = reg_write && reg_addr == MODE_ADDR;
  sequence fault_seen;
    frame_crc_fail && cfg_mode.rx_crc_en;
  endsequence
  sequence status_read;
    reg_read && reg_addr == STATUS_ADDR;
  endsequence
  // config must stay put for a cycle, else the pin follows the new source
  sequence ready_rise;
    (conv_done & cfg_clock.chan_convert_enable) != 8'h00 && !reg_write &&
    !data_frame_read && cfg_mode.ready_pin_source_select == SRC_ANY &&
    !cfg_mode.ready_pin_pulse_format ##1 !data_frame_read && !reg_write;
  endsequence
  chk_reset_values: assert property (
    $fell(rst) |-> cfg_mode == MODE_RESET && cfg_clock == CLOCK_RESET)
    else $error("register reset value wrong");
  chk_mode_write: assert property (
    wr_mode |=> (cfg_mode & 16'hfbff) ==
      ($past(reg_wdata) & MODE_WMASK & 16'hfbff))
    else $error("mode write not taken");
  chk_clock_write: assert property (
    reg_write && reg_addr == CLOCK_ADDR |=>
      cfg_clock == ($past(reg_wdata) & CLOCK_WMASK))
    else $error("clock write not taken");
  chk_reset_ack: assert property (
    wr_mode && !reg_wdata[10] |=> !cfg_mode.reset_seen)
    else $error("reset flag not cleared");
  chk_reset_keep: assert property (
    wr_mode && reg_wdata[10] |=> $stable(cfg_mode.reset_seen))
    else $error("reset flag changed by writing one");
  chk_read_answer: assert property (reg_read |=> reg_rvalid)
    else $error("read not answered");
  chk_no_stray: assert property (reg_rvalid |-> $past(reg_read))
    else $error("read valid without request");
  chk_frame_flag: assert property (
    fault_seen ##1 status_read |=> reg_rdata[12])
    else $error("frame crc flag missing");
  chk_pin_low: assert property (
    ready_rise |=> !data_ready_pin_out && data_ready_pin_oe)
    else $error("data-ready pin not low");
  chk_float_idle: assert property (
    !data_ready_pin_oe |-> data_ready_pin_out)
    else $error("pin floated while signalling");
endmodule
bind adc_config_regs adc_config_regs_checker #(.PULSE_CYCLES(PULSE_CYCLES))
  u_chk (.clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .frame_crc_fail(frame_crc_fail),
  .conv_done(conv_done), .data_frame_read(data_frame_read),
  .cfg_mode(cfg_mode), .cfg_clock(cfg_clock),
  .data_ready_pin_out(data_ready_pin_out),
  .data_ready_pin_oe(data_ready_pin_oe));
`default_nettype wire

// ==== host_model.sv ====
// Purpose: host side of the decoded register access
// Assumes: one-cycle request pulses, driven at the falling edge
// Notes: wdata is scrambled after release so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // requests
  output logic reg_write,
  output logic reg_read,
  output logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
  output logic [adc_cfg_pkg::DATA_W-1:0] reg_wdata,
  // answers
  input wire logic [adc_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  import adc_cfg_pkg::*;
  ////////////////////////////////////////
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d & (a == MODE_ADDR ? MODE_WMASK : CLOCK_WMASK);
    @(negedge clk);
    reg_write = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_read = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 1'b0;
    for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++) @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== adc_config_regs_tb.sv ====
// Purpose: self-checking bench for the configuration bank
// Assumes: host_model drives the register side
// Notes: pulse width set to 3 to prove the parameter is honoured
`timescale 1ns/1ps
`default_nettype none
module adc_config_regs_tb;
  import adc_cfg_pkg::*;
  ////////////////////////////////////////
  localparam int PW = 3;
  logic clk, rst, reg_write, reg_read, reg_rvalid, fail, dfr, pin, oe;
  logic [5:0] addr;
  logic [15:0] wdata, rdata, d, w, em;
  logic [7:0] done;
  mode_cfg_t cfg_mode;
  clock_cfg_t cfg_clock;
  int bad_count, n_compared, seed, rbit;
  adc_config_regs #(.PULSE_CYCLES(PW)) u_adc_config_regs (.clk(clk),
    .rst(rst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(reg_rvalid),
    .frame_crc_fail(fail), .conv_done(done), .data_frame_read(dfr),
    .cfg_mode(cfg_mode), .cfg_clock(cfg_clock), .data_ready_pin_out(pin),
    .data_ready_pin_oe(oe));
  host_model u_host_model (.clk(clk), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .reg_rvalid(reg_rvalid));
  task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // the reset bit only ever falls, so a written one keeps the old value
  function automatic logic [15:0] exp_mode(logic [15:0] v, logic r);
    return (v & MODE_WMASK & 16'hfbff) | {5'h00, r & v[10], 10'h000};
  endfunction
  task automatic ready_case(logic [15:0] m, logic [7:0] ch, logic lo);
    u_host_model.wr(MODE_ADDR, m);
    @(negedge clk) done = ch;
    @(negedge clk) done = 8'h00;
    for (int k = 0; k < (m[0] ? PW : 1); k++) begin
      @(negedge clk);
      chk("pin", {15'h0, ~lo}, {15'h0, pin});
    end
    @(negedge clk);
    chk("pin after", {15'h0, ~lo | m[0]}, {15'h0, pin});
    u_host_model.rd(STATUS_ADDR, d);
    chk("status", {8'h00, ch & em[15:8]}, d);
    @(negedge clk) dfr = 1'b1;
    @(negedge clk) dfr = 1'b0;
    @(negedge clk);
    chk("idle pin", {14'h0, 1'b1, ~m[1]}, {14'h0, pin, oe});
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  initial begin
    seed = 49102;
    rst = 1'b1;
    {fail, dfr, done} = 10'h000;
    rbit = 1;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    u_host_model.rd(CLOCK_ADDR, d);
    chk("clock reset", 16'hff0e, d);
    u_host_model.rd(MODE_ADDR, d);
    chk("mode reset", 16'h0510, d);
    u_host_model.rd(STATUS_ADDR, d);
    chk("status reset", 16'h0500, d);
    u_host_model.rd(6'h2a, d);
    chk("unmapped", 16'h0000, d);
    $display("test reset values done");
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      u_host_model.wr(MODE_ADDR, w);
      em = exp_mode(w, rbit[0]);
      rbit = {31'h0, em[10]};
      u_host_model.rd(MODE_ADDR, d);
      chk("mode", em, d);
      chk("cfg mode", em, cfg_mode);
      u_host_model.rd(STATUS_ADDR, d);
      chk("status", {4'h0, em[11:8], 8'h00}, d);
      u_host_model.wr(CLOCK_ADDR, w);
      u_host_model.rd(CLOCK_ADDR, d);
      chk("clock", w & CLOCK_WMASK, d);
      chk("cfg clock", w & CLOCK_WMASK, cfg_clock);
    end
    $display("test random fields done");
    em = 16'h0f0e;
    u_host_model.wr(CLOCK_ADDR, em);
    ready_case(16'h0004, 8'hf0, 1'b0);
    em = 16'hff0e;
    u_host_model.wr(CLOCK_ADDR, em);
    for (int s = 0; s < 4; s++) begin
      ready_case({12'h000, s[1:0], 2'b00}, 8'h3c, s != 0);
    end
    ready_case(16'h0000, 8'hff, 1'b1);
    ready_case(16'h0006, 8'h81, 1'b1);
    ready_case(16'h0005, 8'h42, 1'b1);
    $display("test data ready pin done");
    for (int e = 0; e < 2; e++) begin
      u_host_model.wr(MODE_ADDR, e ? 16'h3000 : 16'h2000);
      @(negedge clk) fail = 1'b1;
      // read right behind the bad frame so the flag assertion is reached
      fork
        u_host_model.rd(STATUS_ADDR, d);
        @(negedge clk) fail = 1'b0;
      join
      chk("crc flag", e ? 16'h1000 : 16'h0000, d);
      u_host_model.rd(STATUS_ADDR, d);
      chk("crc flag cleared", 16'h0000, d);
    end
    $display("test crc flags done");
    end_sim;
  end
endmodule
`default_nettype wire
